// *** mior_regmap.v ***
// Purpose: live i/o coil and register map behind a modbus slave
// Assumes: an upstream parser hands over one single-register request at a time
// Notes:   answer appears one clock after the request is taken
`timescale 1ns/100ps
`include "mior_consts.vh"

// Summary of operation
// - requests touching unimplemented addresses get an exception, not a reply
// - coil and 16-bit register spaces are decoded separately, each 65536 positions
// - single-bit reads are refused; bit states come from register reads
// - protocol address N selects device register N plus one
// - outputs change by coil or register write; output register reads them back
// - only coils 0 to 7 exist, driving outputs one to eight
// - writing register one sets all eight outputs, bit 0 is output one
// - register two returns the eight input levels in bits 0 to 7
// - each analog input is a 10-bit unsigned sample refreshed at 62.5 Hz
// - registers three to ten return analog inputs zero to seven in order
// - an attached temperature sensor replaces that input's analog value
module mior_regmap #(
  parameter SAMPLE_CYCLES = `MIOR_SAMPLE_CYCLES
) (
  // clock and reset
  input  wire        I_REF_CLK,
  input  wire        I_SRST,
  // request from the frame parser
  input  wire        I_REQ_VALID,
  input  wire [7:0]  I_REQ_FUNC,
  input  wire [15:0] I_REQ_ADDR,
  input  wire [15:0] I_REQ_WDATA,
  // answer to the frame builder
  output reg         O_RSP_VALID,
  output reg         O_RSP_EXC,
  output reg  [7:0]  O_RSP_EXC_CODE,
  output reg  [15:0] O_RSP_DATA,
  // i/o pins
  output reg  [7:0]  O_OUTPUTS,
  input  wire [7:0]  I_INPUTS,
  // analog converter
  output wire        O_ADC_START,
  output wire [2:0]  O_ADC_CHAN,
  input  wire        I_ADC_DONE,
  input  wire [9:0]  I_ADC_DATA,
  // digital_temp_sensor readings
  input  wire [7:0]  I_DIGITAL_TEMP_SENSOR_PRESENT,
  input  wire        I_DIGITAL_TEMP_SENSOR_VALID,
  input  wire [2:0]  I_DIGITAL_TEMP_SENSOR_CHAN,
  input  wire [15:0] I_DIGITAL_TEMP_SENSOR_TEMP
);

  wire        dec_exc;
  wire [7:0]  dec_exc_code;
  wire        dec_rd;
  wire [3:0]  dec_rd_sel;
  wire        dec_wr_outputs;
  wire        dec_wr_coil;
  wire [2:0]  dec_coil_idx;
  wire        dec_coil_val;
  wire [79:0] samples;

  reg  [7:0]  inputs_r;
  reg  [15:0] temp_r [0:7];
  reg  [7:0]  out_nxt;
  reg  [15:0] rd_data;
  wire [15:0] analog_w [0:7];
  integer     k;

  mior_decode u_decode (
    .i_func       (I_REQ_FUNC),
    .i_addr       (I_REQ_ADDR),
    .i_wdata      (I_REQ_WDATA),
    .o_exc        (dec_exc),
    .o_exc_code   (dec_exc_code),
    .o_rd         (dec_rd),
    .o_rd_sel     (dec_rd_sel),
    .o_wr_outputs (dec_wr_outputs),
    .o_wr_coil    (dec_wr_coil),
    .o_coil_idx   (dec_coil_idx),
    .o_coil_val   (dec_coil_val)
  );

  mior_sampler #(
    .SAMPLE_CYCLES (SAMPLE_CYCLES),
    .ADC_BITS      (`MIOR_ADC_BITS)
  ) u_sampler (
    .i_clk       (I_REF_CLK),
    .i_srst      (I_SRST),
    .o_adc_start (O_ADC_START),
    .o_adc_chan  (O_ADC_CHAN),
    .i_adc_done  (I_ADC_DONE),
    .i_adc_data  (I_ADC_DATA),
    .o_samples   (samples)
  );

  // sensor word wins over the zero-extended voltage sample
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_analog
      assign analog_w[g] = I_DIGITAL_TEMP_SENSOR_PRESENT[g] ? temp_r[g]
                                                            : {6'h00, samples[g*10 +: 10]};
    end
  endgenerate

  always @* begin
    rd_data = 16'h0000;
    case (dec_rd_sel)
      4'h1:    rd_data = {8'h00, O_OUTPUTS};
      4'h2:    rd_data = {8'h00, inputs_r};
      4'h3:    rd_data = analog_w[0];
      4'h4:    rd_data = analog_w[1];
      4'h5:    rd_data = analog_w[2];
      4'h6:    rd_data = analog_w[3];
      4'h7:    rd_data = analog_w[4];
      4'h8:    rd_data = analog_w[5];
      4'h9:    rd_data = analog_w[6];
      4'hA:    rd_data = analog_w[7];
      default: rd_data = 16'h0000;
    endcase
  end

  always @* begin
    out_nxt = O_OUTPUTS;
    if (I_REQ_VALID && !dec_exc) begin
      if (dec_wr_outputs) begin
        out_nxt = I_REQ_WDATA[7:0];
      end else if (dec_wr_coil) begin
        out_nxt[dec_coil_idx] = dec_coil_val;
      end
    end
  end

  always @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      O_OUTPUTS      <= `MIOR_OUT_RESET;
      inputs_r       <= 8'h00;
      O_RSP_VALID    <= 1'b0;
      O_RSP_EXC      <= 1'b0;
      O_RSP_EXC_CODE <= `MIOR_EXC_NONE;
      O_RSP_DATA     <= 16'h0000;
      for (k = 0; k < 8; k = k + 1) begin
        temp_r[k] <= `MIOR_TEMP_RESET;
      end
    end else begin
      O_OUTPUTS   <= out_nxt;
      inputs_r    <= I_INPUTS;
      O_RSP_VALID <= I_REQ_VALID;
      if (I_DIGITAL_TEMP_SENSOR_VALID) begin
        temp_r[I_DIGITAL_TEMP_SENSOR_CHAN] <= I_DIGITAL_TEMP_SENSOR_TEMP;
      end
      if (I_REQ_VALID) begin
        O_RSP_EXC      <= dec_exc;
        O_RSP_EXC_CODE <= dec_exc_code;
        // writes echo their value, reads return the register
        O_RSP_DATA     <= dec_exc ? 16'h0000 : (dec_rd ? rd_data : I_REQ_WDATA);
      end
    end
  end

endmodule // mior_regmap

// *** mior_consts.vh ***
// Purpose: shared constants of the modbus i/o register map
// Assumes: included by bare name from every design file
// Notes:   definitions only
`ifndef MIOR_CONSTS_VH
`define MIOR_CONSTS_VH

// function codes seen from the frame parser
`define MIOR_FC_RD_COILS      8'h01
`define MIOR_FC_RD_DISC       8'h02
`define MIOR_FC_RD_HOLD       8'h03
`define MIOR_FC_RD_INPUT      8'h04
`define MIOR_FC_WR_COIL       8'h05
`define MIOR_FC_WR_REG        8'h06

// exception codes
`define MIOR_EXC_NONE         8'h00
`define MIOR_EXC_ILL_FUNC     8'h01
`define MIOR_EXC_ILL_ADDR     8'h02
`define MIOR_EXC_ILL_VALUE    8'h03

// device register numbers (protocol address plus one)
`define MIOR_DEV_OFFSET       17'h00001
`define MIOR_REG_OUTPUT       17'h00001
`define MIOR_REG_INPUT        17'h00002
`define MIOR_REG_ANALOG0      17'h00003
`define MIOR_REG_ANALOG7      17'h0000A

// coil map
`define MIOR_COIL_LAST        16'h0007
`define MIOR_COIL_ON          16'hFF00
`define MIOR_COIL_OFF         16'h0000

// reset values
`define MIOR_OUT_RESET        8'h00
`define MIOR_TEMP_RESET       16'h0000

// sizes
`define MIOR_NUM_IO           8
`define MIOR_ADC_BITS         10

// timing: 62.5 Hz per input is a 16 ms period
`define MIOR_CLK_PERIOD_NS    4
`define MIOR_SAMPLE_PERIOD_NS 16000000
`define MIOR_SAMPLE_CYCLES    (`MIOR_SAMPLE_PERIOD_NS / `MIOR_CLK_PERIOD_NS)

`endif

// *** mior_decode.v ***
// Purpose: classify one modbus request against the implemented map
// Assumes: request fields are stable while decoded
// Notes:   purely combinational
`timescale 1ns/100ps
`include "mior_consts.vh"

module mior_decode (
  // request
  input  wire [7:0]  i_func,
  input  wire [15:0] i_addr,
  input  wire [15:0] i_wdata,
  // classification
  output reg         o_exc,
  output reg  [7:0]  o_exc_code,
  output reg         o_rd,
  output reg  [3:0]  o_rd_sel,
  output reg         o_wr_outputs,
  output reg         o_wr_coil,
  output reg  [2:0]  o_coil_idx,
  output reg         o_coil_val
);

  wire [16:0] dev_num;

  // 17 bits so address 0xFFFF cannot wrap onto register 0
  assign dev_num = {1'b0, i_addr} + `MIOR_DEV_OFFSET;

  always @* begin
    o_exc        = 1'b0;
    o_exc_code   = `MIOR_EXC_NONE;
    o_rd         = 1'b0;
    o_rd_sel     = 4'h0;
    o_wr_outputs = 1'b0;
    o_wr_coil    = 1'b0;
    o_coil_idx   = i_addr[2:0];
    o_coil_val   = 1'b0;
    case (i_func)
      `MIOR_FC_RD_COILS, `MIOR_FC_RD_DISC: begin
        o_exc      = 1'b1;
        o_exc_code = `MIOR_EXC_ILL_FUNC;
      end
      `MIOR_FC_RD_HOLD, `MIOR_FC_RD_INPUT: begin
        if (dev_num >= `MIOR_REG_OUTPUT && dev_num <= `MIOR_REG_ANALOG7) begin
          o_rd     = 1'b1;
          o_rd_sel = dev_num[3:0];
        end else begin
          o_exc      = 1'b1;
          o_exc_code = `MIOR_EXC_ILL_ADDR;
        end
      end
      `MIOR_FC_WR_COIL: begin
        if (i_addr > `MIOR_COIL_LAST) begin
          o_exc      = 1'b1;
          o_exc_code = `MIOR_EXC_ILL_ADDR;
        end else if (i_wdata == `MIOR_COIL_ON || i_wdata == `MIOR_COIL_OFF) begin
          o_wr_coil  = 1'b1;
          o_coil_val = (i_wdata == `MIOR_COIL_ON);
        end else begin
          o_exc      = 1'b1;
          o_exc_code = `MIOR_EXC_ILL_VALUE;
        end
      end
      `MIOR_FC_WR_REG: begin
        if (dev_num == `MIOR_REG_OUTPUT) begin
          o_wr_outputs = 1'b1;
        end else begin
          o_exc      = 1'b1;
          o_exc_code = `MIOR_EXC_ILL_ADDR;
        end
      end
      default: begin
        o_exc      = 1'b1;
        o_exc_code = `MIOR_EXC_ILL_FUNC;
      end
    endcase
  end

endmodule // mior_decode

// *** mior_sampler.v ***
// Purpose: round-robin conversion scheduler for the eight analog inputs
// Assumes: converter answers each start with one done pulse
// Notes:   each input is converted once per SAMPLE_CYCLES unless a conversion outlasts its slot
`timescale 1ns/100ps
`include "mior_consts.vh"

module mior_sampler #(
  parameter SAMPLE_CYCLES = `MIOR_SAMPLE_CYCLES,
  parameter ADC_BITS      = `MIOR_ADC_BITS
) (
  // clock and reset
  input  wire                  i_clk,
  input  wire                  i_srst,
  // converter
  output reg                   o_adc_start,
  output reg  [2:0]            o_adc_chan,
  input  wire                  i_adc_done,
  input  wire [ADC_BITS-1:0]   i_adc_data,
  // captured samples, input 0 in the low slice
  output wire [8*ADC_BITS-1:0] o_samples
);

  localparam [31:0] SLOT_CYCLES = SAMPLE_CYCLES / 8;

  reg [31:0]         slot_cnt_r;
  reg                busy_r;
  reg [ADC_BITS-1:0] samp_r [0:7];
  integer            k;

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_flat
      assign o_samples[g*ADC_BITS +: ADC_BITS] = samp_r[g];
    end
  endgenerate

  // a slow conversion delays the next start rather than overlapping it
  always @(posedge i_clk) begin
    if (i_srst) begin
      slot_cnt_r  <= 32'h0;
      busy_r      <= 1'b0;
      o_adc_start <= 1'b0;
      o_adc_chan  <= 3'h7;
      for (k = 0; k < 8; k = k + 1) begin
        samp_r[k] <= {ADC_BITS{1'b0}};
      end
    end else begin
      o_adc_start <= 1'b0;
      if (slot_cnt_r < SLOT_CYCLES - 32'h1) begin
        slot_cnt_r <= slot_cnt_r + 32'h1;
      end
      if (busy_r && i_adc_done) begin
        samp_r[o_adc_chan] <= i_adc_data;
        busy_r             <= 1'b0;
      end else if (!busy_r && slot_cnt_r >= SLOT_CYCLES - 32'h1) begin
        slot_cnt_r  <= 32'h0;
        busy_r      <= 1'b1;
        o_adc_start <= 1'b1;
        o_adc_chan  <= o_adc_chan + 3'h1;
      end
    end
  end

endmodule // mior_sampler

// *** mior_monitor.sv ***
// Purpose: port assertions for mior_regmap
// Assumes: one clock, sync active high reset
// Notes:   bound to every regmap instance
`timescale 1ns/100ps
module mior_monitor (
  input wire        I_REF_CLK, I_SRST, I_REQ_VALID, O_RSP_VALID, O_RSP_EXC, I_ADC_DONE, O_ADC_START,
  input wire [2:0]  O_ADC_CHAN,
  input wire [7:0]  I_REQ_FUNC, I_INPUTS, O_OUTPUTS, O_RSP_EXC_CODE,
  input wire [15:0] I_REQ_ADDR, I_REQ_WDATA, O_RSP_DATA
);
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_SRST);
  wire        v   = I_REQ_VALID;
  wire [7:0]  f   = I_REQ_FUNC;
  wire [15:0] a   = I_REQ_ADDR;
  wire        rd  = v && (f == 8'h03 || f == 8'h04);
  wire        wr  = v && f == 8'h06;
  wire [7:0]  wlo = I_REQ_WDATA[7:0];
  wire [2:0]  ci  = a[2:0];
  a_rsp_per_req: assert property (v |=> O_RSP_VALID) else $error("no answer");
  a_no_stray_rsp: assert property (!v |=> !O_RSP_VALID) else $error("stray answer");
  a_rd_bad_addr: assert property (rd && a > 16'h0009 |=> O_RSP_EXC && O_RSP_EXC_CODE == 8'h02)
    else $error("read past map");
  a_bit_rd_refused: assert property (v && (f == 8'h01 || f == 8'h02) |=> O_RSP_EXC_CODE == 8'h01)
    else $error("bit read");
  a_exc_keeps_out: assert property (wr && a != 16'h0000 |=> $stable(O_OUTPUTS))
    else $error("outputs moved");
  a_reg_sets_all: assert property (wr && a == 16'h0000 |=> O_OUTPUTS == $past(wlo))
    else $error("reg write");
  a_coil_sets_bit: assert property (v && f == 8'h05 && a < 16'h0008 && I_REQ_WDATA == 16'hFF00
    |=> O_OUTPUTS[$past(ci)]) else $error("coil write");
  a_coil_clears_bit: assert property (v && f == 8'h05 && a < 16'h0008 && I_REQ_WDATA == 16'h0000
    |=> !O_OUTPUTS[$past(ci)]) else $error("coil clear");
  a_in_read_bits: assert property (rd && a == 16'h0001 |=> O_RSP_DATA == {8'h00, $past(I_INPUTS, 2)})
    else $error("input read");
  a_out_readback: assert property (rd && a == 16'h0000 |=> O_RSP_DATA == {8'h00, $past(O_OUTPUTS)})
    else $error("output read");
  a_start_pulse: assert property (O_ADC_START |=> !O_ADC_START) else $error("start held");
  a_chan_steps: assert property (O_ADC_START |-> O_ADC_CHAN == 3'($past(O_ADC_CHAN) + 3'h1))
    else $error("channel order");
  a_chan_holds: assert property (!O_ADC_START |-> $stable(O_ADC_CHAN)) else $error("channel moved");
  c_coil: cover property (v && f == 8'h05);
  c_exc: cover property (O_RSP_VALID && O_RSP_EXC);
  c_adc: cover property (I_ADC_DONE);
endmodule // mior_monitor
bind mior_regmap mior_monitor i_mior_monitor (.I_REF_CLK, .I_SRST, .I_REQ_VALID, .O_RSP_VALID, .O_RSP_EXC,
  .I_ADC_DONE, .O_ADC_START, .O_ADC_CHAN, .I_REQ_FUNC, .I_INPUTS, .O_OUTPUTS, .O_RSP_EXC_CODE, .I_REQ_ADDR,
  .I_REQ_WDATA, .O_RSP_DATA);

// *** mior_adc_model.sv ***
// Purpose: converter on the far side of the sampler
// Assumes: one start per conversion
// Notes:   latency set by the bench
`timescale 1ns/100ps
module mior_adc_model (
  input  wire        i_clk,
  input  wire        i_srst,
  input  wire        i_start,
  input  wire [2:0]  i_chan,
  input  wire [3:0]  i_lat,
  input  wire [79:0] i_vals,
  output reg         o_done,
  output reg  [9:0]  o_data
);
  reg [4:0] cnt_r = 5'h00;
  reg [2:0] chan_r = 3'h0;
  reg       busy_r = 1'b0;
  initial o_done = 1'b0;
  initial o_data = 10'h000;
  always @(posedge i_clk) begin
    o_done <= 1'b0;
    // result only valid with done, never left standing
    o_data <= ~o_data;
    if (i_srst) begin
      busy_r <= 1'b0;
    end else if (i_start) begin
      busy_r <= 1'b1;
      cnt_r  <= {1'b0, i_lat};
      chan_r <= i_chan;
    end else if (busy_r && cnt_r == 5'h00) begin
      busy_r <= 1'b0;
      o_done <= 1'b1;
      o_data <= i_vals[chan_r*10 +: 10];
    end else begin
      cnt_r <= cnt_r - 5'h01;
    end
  end
endmodule // mior_adc_model

// *** mior_regmap_tb_top.sv ***
// Purpose: random and corner requests against mior_regmap
// Assumes: answer one clock after the request
// Notes:   short sample period for speed
`timescale 1ns/100ps
module mior_regmap_tb_top;
  reg I_REF_CLK = 1'b0, I_SRST = 1'b1, I_REQ_VALID = 1'b0, I_DIGITAL_TEMP_SENSOR_VALID = 1'b0;
  reg [7:0] I_REQ_FUNC = 8'h00, I_INPUTS = 8'h3C, I_DIGITAL_TEMP_SENSOR_PRESENT = 8'h00;
  reg [15:0] I_REQ_ADDR = 16'h0000, I_REQ_WDATA = 16'h0000, I_DIGITAL_TEMP_SENSOR_TEMP = 16'h0000;
  reg [2:0] I_DIGITAL_TEMP_SENSOR_CHAN = 3'h0;
  reg [3:0] lat = 4'h0;
  reg [79:0] vals = 80'h0;
  wire O_RSP_VALID, O_RSP_EXC, O_ADC_START, I_ADC_DONE;
  wire [7:0] O_RSP_EXC_CODE, O_OUTPUTS;
  wire [15:0] O_RSP_DATA;
  wire [2:0] O_ADC_CHAN;
  wire [9:0] I_ADC_DATA;
  reg [7:0] out_m = 8'h00;
  reg [15:0] temp_m [0:7];
  reg [15:0] e;
  integer num_errors = 0, n_tests = 0, i;
  always #2 I_REF_CLK = ~I_REF_CLK;
  mior_regmap #(.SAMPLE_CYCLES(80)) i_mior_regmap (.I_REF_CLK, .I_SRST, .I_REQ_VALID, .I_REQ_FUNC, .I_REQ_ADDR,
    .I_REQ_WDATA, .O_RSP_VALID, .O_RSP_EXC, .O_RSP_EXC_CODE, .O_RSP_DATA, .O_OUTPUTS, .I_INPUTS, .O_ADC_START,
    .O_ADC_CHAN, .I_ADC_DONE, .I_ADC_DATA, .I_DIGITAL_TEMP_SENSOR_PRESENT, .I_DIGITAL_TEMP_SENSOR_VALID,
    .I_DIGITAL_TEMP_SENSOR_CHAN, .I_DIGITAL_TEMP_SENSOR_TEMP);
  mior_adc_model i_mior_adc_model (.i_clk(I_REF_CLK), .i_srst(I_SRST), .i_start(O_ADC_START),
    .i_chan(O_ADC_CHAN), .i_lat(lat), .i_vals(vals), .o_done(I_ADC_DONE), .o_data(I_ADC_DATA));
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  function [7:0] ecode(input [7:0] f, input [15:0] a, input [15:0] w);
    begin
      if (f == 8'h03 || f == 8'h04) ecode = (a > 16'h0009) ? 8'h02 : 8'h00;
      else if (f == 8'h06) ecode = (a != 16'h0000) ? 8'h02 : 8'h00;
      else if (f == 8'h05) ecode = (a > 16'h0007) ? 8'h02 : (w != 16'hFF00 && w != 16'h0000) ? 8'h03 : 8'h00;
      else ecode = 8'h01;
    end
  endfunction
  function [15:0] rdat(input [15:0] a);
    begin
      if (a == 16'h0000) rdat = {8'h00, out_m};
      else if (a == 16'h0001) rdat = {8'h00, I_INPUTS};
      else if (I_DIGITAL_TEMP_SENSOR_PRESENT[a-2]) rdat = temp_m[a-2];
      else rdat = {6'h00, vals[(a-2)*10 +: 10]};
    end
  endfunction
  task req(input [7:0] f, input [15:0] a, input [15:0] w);
    reg [7:0] c;
    reg [15:0] d;
    begin
      c = ecode(f, a, w);
      d = (c != 8'h00) ? 16'h0000 : (f == 8'h05 || f == 8'h06) ? w : rdat(a);
      if (c == 8'h00 && f == 8'h06) out_m = w[7:0];
      if (c == 8'h00 && f == 8'h05) out_m[a[2:0]] = (w == 16'hFF00);
      @(posedge I_REF_CLK);
      I_REQ_VALID <= 1'b1;
      I_REQ_FUNC <= f;
      I_REQ_ADDR <= a;
      I_REQ_WDATA <= w;
      @(posedge I_REF_CLK);
      I_REQ_VALID <= 1'b0;
      I_INPUTS <= 8'($urandom);
      #1;
      chk(O_RSP_VALID, 1'b1);
      chk(O_RSP_EXC, c != 8'h00);
      chk(O_RSP_EXC_CODE, c);
      chk(O_RSP_DATA, d);
      chk(O_OUTPUTS, out_m);
    end
  endtask
  task complete_run;
    begin
      $display("errors %0d comparisons %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial begin
    i = $urandom(32'h91ba);
    vals = 80'({$urandom, $urandom, $urandom});
    lat = 4'($urandom);
    repeat (10) @(posedge I_REF_CLK);
    I_SRST <= 1'b0;
    #1;
    chk(O_OUTPUTS, 8'h00);
    chk(O_ADC_CHAN, 3'h7);
    for (i = 0; i < 8; i = i + 1) begin
      e = 16'($urandom);
      temp_m[i] = e;
      @(posedge I_REF_CLK);
      I_DIGITAL_TEMP_SENSOR_VALID <= 1'b1;
      I_DIGITAL_TEMP_SENSOR_CHAN <= i[2:0];
      I_DIGITAL_TEMP_SENSOR_TEMP <= e;
    end
    @(posedge I_REF_CLK);
    I_DIGITAL_TEMP_SENSOR_VALID <= 1'b0;
    I_DIGITAL_TEMP_SENSOR_PRESENT <= 8'($urandom);
    // slow converter stretches a full round past 8 slots
    repeat (400) @(posedge I_REF_CLK);
    req(8'h06, 16'h0000, 16'h00A5);
    req(8'h04, 16'h000A, 16'h0000);
    req(8'h03, 16'hFFFF, 16'h0000);
    req(8'h05, 16'h0008, 16'hFF00);
    req(8'h05, 16'h0000, 16'h1234);
    for (i = 0; i < 400; i = i + 1) begin
      e = (i % 3 == 0) ? 16'h0000 : (i % 3 == 1) ? 16'hFF00 : 16'($urandom);
      req(8'($urandom % 8), 16'($urandom % 12), e);
    end
    // new converter values must show up within one full round
    @(posedge I_REF_CLK);
    vals <= 80'({$urandom, $urandom, $urandom});
    I_DIGITAL_TEMP_SENSOR_PRESENT <= 8'h00;
    repeat (300) @(posedge I_REF_CLK);
    for (i = 2; i < 10; i = i + 1) begin
      req(8'h04, i[15:0], 16'h0000);
    end
    // mid-run reset drops outputs back to their reset state
    @(posedge I_REF_CLK);
    I_SRST <= 1'b1;
    repeat (2) @(posedge I_REF_CLK);
    I_SRST <= 1'b0;
    out_m = 8'h00;
    #1;
    chk(O_OUTPUTS, 8'h00);
    chk(O_RSP_VALID, 1'b0);
    chk(O_ADC_START, 1'b0);
    chk(O_ADC_CHAN, 3'h7);
    req(8'h03, 16'h0000, 16'h0000);
    complete_run;
  end
endmodule // mior_regmap_tb_top
